// File: tcv_consts.svh
`ifndef TCV_CONSTS_SVH
`define TCV_CONSTS_SVH
`define TCV_OFF_CSC 12'h000
`define TCV_OFF_VHI 12'h004
`define TCV_OFF_VLO 12'h008
`define TCV_OFF_GCTL 12'h00C
`define TCV_OFF_STAT 12'h010
`define TCV_CSC_FLAG 7
`define TCV_CSC_IE 6
`define TCV_CSC_MSB 5
`define TCV_CSC_MSA 4
`define TCV_CSC_ELSB 3
`define TCV_CSC_ELSA 2
`define TCV_GCTL_CENTER_PWM_MODE 0
`define TCV_GCTL_CLKA 1
`define TCV_GCTL_CLKB 2
`define TCV_FREE_TOP 16'hFFFF
`define TCV_FREE_PRE 16'hFFFE
`define TCV_CLK_NONE 2'h0
`endif

// File: tcv_pkg.sv
package tcv_pkg;
    typedef enum logic [2:0] {
        TCV_PIN_FREE,
        TCV_CAPTURE,
        TCV_COMPARE,
        TCV_EDGE_PWM,
        TCV_CENTER_PWM
    } tcv_mode_t;
endpackage

// File: tcv_channel.sv
// How it works
// - Edge/level 00 releases the pin whatever the other mode bits.
// - Centre 0, mode 00: capture rising, falling or both edges.
// - Centre 0, mode 01: compare match toggles, clears or sets the pin.
// - Compare with edge/level 00 flags matches but leaves the pin alone.
// - Centre 0, mode 1X: edge PWM, 10 high-true, X1 low-true.
// - Centre 1: centre PWM, acts on up-count matches, 10 high-true, X1 low-true.
// - Reset clears both value bytes.
// - Capture mode: a byte read snapshots both until the other byte is read.
// - Any status/control write unlatches read and write coherency.
// - Value byte writes are ignored in capture mode.
// - Debug freezes the read latch; only status/control write resets it.
// - Debug value reads return live register contents.
// - Compare/PWM writes buffer; transfer needs both bytes, any order.
// - No clock selected: transfer as soon as the second byte lands.
// - Clock on, compare: transfer at next counter step.
// - Clock on, PWM: transfer as counter steps modulo-1 to modulo.
// - Debug freezes the write latch state too.
// - Debug value writes go straight to the channel register.
// - Debug writes leave a partial buffered sequence intact.
// - Flag sets on capture edge or match, not at 0% or 100% PWM.
// - Flag clears by read-while-set then write 0; new event wins.
// - Clock select 00 means no clock, counter off.
`timescale 1ns/1ps
`default_nettype none
`include "tcv_consts.svh"
module tcv_channel (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic [15:0] COUNT_I,
    input wire logic [15:0] MODULO_I,
    input wire logic COUNT_UP_I,
    input wire logic COUNT_STEP_I,
    input wire logic DEBUG_ACTIVE_I,
    input wire logic CHAN_PIN_I,
    output logic CHAN_PIN_O,
    output logic CHAN_PIN_OE_O,
    output logic CHAN_IRQ_O,
    output tcv_pkg::tcv_mode_t MODE_O
);
    import tcv_pkg::*;

    logic [7:0] csc_q, csc_d;
    logic [2:0] gctl_q;
    logic [15:0] val_q, val_d;
    logic [15:0] wbuf_q, wbuf_d;
    logic [15:0] rbuf_q;
    logic rlat_q, rlat_d;
    // Which half opened the read latch; the other half or a status/control write closes it
    logic rfirst_q, rfirst_d;
    logic whi_q, whi_d, wlo_q, wlo_d;
    logic pend_q, pend_d;
    logic flag_armed_q, flag_armed_d;
    logic pin_q, pin_d;
    logic [2:0] pin_sync_q;
    logic [15:0] count_prev_q;

    wire wr = PSEL_I & PENABLE_I & PWRITE_I;
    wire rd = PSEL_I & PENABLE_I & ~PWRITE_I;
    wire sel_csc = PADDR_I == `TCV_OFF_CSC;
    wire sel_vhi = PADDR_I == `TCV_OFF_VHI;
    wire sel_vlo = PADDR_I == `TCV_OFF_VLO;
    wire sel_gctl = PADDR_I == `TCV_OFF_GCTL;
    wire sel_stat = PADDR_I == `TCV_OFF_STAT;
    wire mapped = sel_csc | sel_vhi | sel_vlo | sel_gctl | sel_stat;
    wire [1:0] els = {csc_q[`TCV_CSC_ELSB], csc_q[`TCV_CSC_ELSA]};
    wire [1:0] msel = {csc_q[`TCV_CSC_MSB], csc_q[`TCV_CSC_MSA]};
    wire center = gctl_q[`TCV_GCTL_CENTER_PWM_MODE];
    wire [1:0] clks = {gctl_q[`TCV_GCTL_CLKB], gctl_q[`TCV_GCTL_CLKA]};
    wire clk_on = clks != `TCV_CLK_NONE;
    wire pin_free = els == 2'h0;
    wire is_cap = ~center & (msel == 2'h0);
    wire is_cmp = ~center & (msel == 2'h1);
    wire is_edge_pwm_mode = ~center & msel[1];
    wire is_pwm = is_edge_pwm_mode | center;
    tcv_mode_t mode;

    always_comb begin
        if (center) begin
            mode = TCV_CENTER_PWM;
        end else if (msel[1]) begin
            mode = TCV_EDGE_PWM;
        end else if (msel[0]) begin
            mode = TCV_COMPARE;
        end else begin
            mode = TCV_CAPTURE;
        end
        if (pin_free && !is_cmp) begin
            mode = TCV_PIN_FREE;
        end
    end

    // Pin is asynchronous: two stages before edge logic
    wire pin_s = pin_sync_q[1];
    wire pin_rise = pin_s & ~pin_sync_q[2];
    wire pin_fall = ~pin_s & pin_sync_q[2];
    wire cap_evt = is_cap & ((els[0] & pin_rise) | (els[1] & pin_fall));
    wire counter_moved = clk_on & COUNT_STEP_I;
    wire match = counter_moved & (COUNT_I == val_q);
    wire [15:0] top = (MODULO_I == 16'h0000) ? `TCV_FREE_TOP : MODULO_I;
    wire [15:0] pre_top = (MODULO_I == 16'h0000) ? `TCV_FREE_PRE : MODULO_I - 16'h0001;
    // 0% and 100% duty raise no flag; free running counts to the full top
    wire duty_edge = (val_q == 16'h0000) | (val_q > top);
    wire pwm_match = is_pwm & match & (~center | COUNT_UP_I) & ~duty_edge;
    wire cmp_match = is_cmp & match;
    wire flag_evt = cap_evt | cmp_match | pwm_match;
    wire pwm_load = counter_moved & (count_prev_q == pre_top) & (COUNT_I == top);
    wire v_write = wr & (sel_vhi | sel_vlo);
    wire both_seen = (whi_q | (wr & sel_vhi)) & (wlo_q | (wr & sel_vlo));
    wire load_now = pend_q & (~clk_on | (is_cmp & counter_moved) | (is_pwm & pwm_load));
    wire [15:0] rd_val = DEBUG_ACTIVE_I ? val_q : (rlat_q ? rbuf_q : val_q);
    wire [31:0] rd_mux = sel_csc ? {24'h000000, csc_q} :
                         sel_vhi ? {24'h000000, rd_val[15:8]} :
                         sel_vlo ? {24'h000000, rd_val[7:0]} :
                         sel_gctl ? {29'h00000000, gctl_q} :
                         sel_stat ? {24'h000000, 1'b0, rlat_q, whi_q, wlo_q, pend_q, mode} : 32'h00000000;

    always_comb begin
        csc_d = csc_q;
        val_d = val_q;
        wbuf_d = wbuf_q;
        rlat_d = rlat_q;
        rfirst_d = rfirst_q;
        whi_d = whi_q;
        wlo_d = wlo_q;
        pend_d = pend_q;
        flag_armed_d = flag_armed_q;
        pin_d = pin_q;
        if (rd && sel_csc && csc_q[`TCV_CSC_FLAG]) begin
            flag_armed_d = 1'b1;
        end
        if (wr && sel_csc) begin
            csc_d[6:2] = PWDATA_I[6:2];
            if (!PWDATA_I[`TCV_CSC_FLAG] && flag_armed_q) begin
                csc_d[`TCV_CSC_FLAG] = 1'b0;
            end
            flag_armed_d = 1'b0;
            rlat_d = 1'b0;
            whi_d = 1'b0;
            wlo_d = 1'b0;
            pend_d = 1'b0;
        end
        if (rd && (sel_vhi || sel_vlo) && is_cap && !DEBUG_ACTIVE_I) begin
            if (!rlat_q) begin
                rlat_d = 1'b1;
                rfirst_d = sel_vhi;
            end else if (sel_vhi != rfirst_q) begin
                rlat_d = 1'b0;
            end
        end
        if (v_write && !is_cap) begin
            if (DEBUG_ACTIVE_I) begin
                if (sel_vhi) begin
                    val_d[15:8] = PWDATA_I[7:0];
                end else begin
                    val_d[7:0] = PWDATA_I[7:0];
                end
            end else begin
                if (sel_vhi) begin
                    wbuf_d[15:8] = PWDATA_I[7:0];
                    whi_d = 1'b1;
                end else begin
                    wbuf_d[7:0] = PWDATA_I[7:0];
                    wlo_d = 1'b1;
                end
                if (both_seen) begin
                    whi_d = 1'b0;
                    wlo_d = 1'b0;
                    pend_d = 1'b1;
                    if (!clk_on) begin
                        val_d = {sel_vhi ? PWDATA_I[7:0] : wbuf_q[15:8], sel_vlo ? PWDATA_I[7:0] : wbuf_q[7:0]};
                        pend_d = 1'b0;
                    end
                end
            end
        end
        // Debug writes touch val only; buffer and latches hold
        if (load_now && !(wr && sel_csc)) begin
            val_d = wbuf_q;
            pend_d = 1'b0;
        end
        if (cap_evt) begin
            val_d = COUNT_I;
        end
        if (cmp_match && !pin_free) begin
            pin_d = (els == 2'h1) ? ~pin_q : els[0];
        end
        if (pwm_match) begin
            pin_d = els[0];
        end
        if (is_pwm && counter_moved && (COUNT_I == 16'h0000 || (center ? 1'b0 : COUNT_I == 16'h0000))) begin
            pin_d = ~els[0];
        end
        if (flag_evt) begin
            csc_d[`TCV_CSC_FLAG] = 1'b1;
            flag_armed_d = 1'b0;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            csc_q <= 8'h00;
            gctl_q <= 3'h0;
            val_q <= 16'h0000;
            wbuf_q <= 16'h0000;
            rlat_q <= 1'b0;
            rfirst_q <= 1'b0;
            whi_q <= 1'b0;
            wlo_q <= 1'b0;
            pend_q <= 1'b0;
            flag_armed_q <= 1'b0;
            pin_q <= 1'b0;
        end else begin
            csc_q <= csc_d;
            val_q <= val_d;
            wbuf_q <= wbuf_d;
            rlat_q <= rlat_d;
            rfirst_q <= rfirst_d;
            whi_q <= whi_d;
            wlo_q <= wlo_d;
            pend_q <= pend_d;
            flag_armed_q <= flag_armed_d;
            pin_q <= pin_d;
            if (wr && sel_gctl) begin
                gctl_q <= PWDATA_I[2:0];
            end
        end
    end

    // Snapshot of the live value when the first half is read
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            rbuf_q <= 16'h0000;
        end else if (rd && (sel_vhi || sel_vlo) && is_cap && !DEBUG_ACTIVE_I && !rlat_q) begin
            rbuf_q <= val_q;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            pin_sync_q <= 3'h0;
            count_prev_q <= 16'h0000;
            PRDATA_O <= 32'h00000000;
        end else begin
            pin_sync_q <= {pin_sync_q[1:0], CHAN_PIN_I};
            if (COUNT_STEP_I) begin
                count_prev_q <= COUNT_I;
            end
            if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
                PRDATA_O <= rd_mux;
            end
        end
    end

    assign PREADY_O = PSEL_I & PENABLE_I;
    assign PSLVERR_O = PSEL_I & PENABLE_I & ~mapped;
    assign CHAN_PIN_O = pin_q;
    assign CHAN_PIN_OE_O = ~pin_free & ~is_cap;
    assign CHAN_IRQ_O = csc_q[`TCV_CSC_FLAG] & csc_q[`TCV_CSC_IE];
    assign MODE_O = mode;
endmodule
`default_nettype wire

// File: tcv_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "tcv_consts.svh"
module tcv_assertions (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    input wire logic CHAN_PIN_OE_O,
    input var tcv_pkg::tcv_mode_t MODE_O
);
    import tcv_pkg::*;
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    wire acc = PSEL_I && PENABLE_I;
    wire cfg_wr = acc && PWRITE_I && (PADDR_I == `TCV_OFF_CSC || PADDR_I == `TCV_OFF_GCTL);
    a_free_undriven: assert property (MODE_O == TCV_PIN_FREE |-> !CHAN_PIN_OE_O)
        else $error("pin driven while released");
    a_capture_undriven: assert property (MODE_O == TCV_CAPTURE |-> !CHAN_PIN_OE_O)
        else $error("pin driven in capture");
    a_pwm_drives: assert property (MODE_O inside {TCV_EDGE_PWM, TCV_CENTER_PWM} |-> CHAN_PIN_OE_O)
        else $error("pwm pin not driven");
    a_mode_by_write: assert property ($changed(MODE_O) |-> $past(cfg_wr))
        else $error("mode changed without config write");
    a_zero_wait: assert property (PSEL_I && !PENABLE_I ##1 PENABLE_I |-> PREADY_O)
        else $error("access phase not ready");
    a_unmapped_err: assert property (acc && PADDR_I > `TCV_OFF_STAT |-> PSLVERR_O)
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (acc && PADDR_I == `TCV_OFF_VHI |-> !PSLVERR_O)
        else $error("mapped access refused");
    a_read_stands: assert property (!(PSEL_I && !PENABLE_I && !PWRITE_I) |=> $stable(PRDATA_O))
        else $error("read data moved outside read setup");
    c_capture: cover property (MODE_O == TCV_CAPTURE);
    c_center: cover property (MODE_O == TCV_CENTER_PWM);
    c_refused: cover property (acc && PSLVERR_O);
endmodule
bind tcv_channel tcv_assertions i_tcv_assertions (.CLK_I(CLK_I), .RST_I(RST_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O),
    .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .CHAN_PIN_OE_O(CHAN_PIN_OE_O), .MODE_O(MODE_O));
`default_nettype wire

// File: tcv_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module tcv_pin_model (
    input wire logic clk_i,
    input wire logic rise_i,
    output logic pin_o
);
    logic [2:0] hold_q = 3'h0;
    // Held four cycles so the two-stage synchroniser sees both edges
    always @(posedge clk_i) begin
        if (rise_i)
            hold_q <= 3'h4;
        else if (hold_q != 3'h0)
            hold_q <= hold_q - 3'h1;
    end
    assign pin_o = (hold_q != 3'h0);
endmodule
`default_nettype wire

// File: tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "tcv_consts.svh"
module tb;
    import tcv_pkg::*;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, step = 0, dbg = 0, rise = 0;
    logic [11:0] pa = 0;
    logic [31:0] pwd = 0, q, prd;
    logic [15:0] cnt = 0;
    logic rdy, err, pin, pin_o, oe, irq, qe;
    tcv_mode_t mode;
    int n_fail = 0, tests_run = 0, cyc = 0;
    initial forever #25 clk = ~clk;
    tcv_channel i_tcv_channel (.CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
        .PADDR_I(pa), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(rdy), .PSLVERR_O(err), .COUNT_I(cnt),
        .MODULO_I(16'h0000), .COUNT_UP_I(1'b0), .COUNT_STEP_I(step), .DEBUG_ACTIVE_I(dbg),
        .CHAN_PIN_I(pin), .CHAN_PIN_O(pin_o), .CHAN_PIN_OE_O(oe), .CHAN_IRQ_O(irq), .MODE_O(mode));
    tcv_pin_model i_tcv_pin_model (.clk_i(clk), .rise_i(rise), .pin_o(pin));
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (rdy !== 1'b1) @(posedge clk);
        q = prd;
        qe = err;
        psel <= 1'b0;
        pen <= 1'b0;
        // Let the access edge settle before anyone looks at outputs
        @(negedge clk);
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e, input string m);
        tests_run++;
        if (s !== e) begin
            n_fail++;
            $display("[FAIL] %0t %s: got %h want %h", $time, m, s, e);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input string m);
        apb(1'b0, a, 32'h0);
        chk(q, e, m);
    endtask
    task automatic pin_edge(input logic [15:0] c);
        @(posedge clk) cnt <= c;
        @(posedge clk) rise <= 1'b1;
        @(posedge clk) rise <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
    task automatic t_reset;
        rd(`TCV_OFF_VHI, 32'h0, "high after reset");
        rd(`TCV_OFF_VLO, 32'h0, "low after reset");
        rd(12'h020, 32'h0, "unmapped read");
        chk({31'h0, qe}, 32'h1, "unmapped refused");
    endtask
    task automatic t_mode;
        tcv_mode_t e;
        for (int i = 0; i < 32; i++) begin
            wr(`TCV_OFF_GCTL, {31'h0, i[4]});
            wr(`TCV_OFF_CSC, {26'h0, i[3:0], 2'b00});
            // Compare with edge/level 00 stays a software compare
            e = (i[1:0] == 2'b00 && (i[4] || i[3:2] != 2'b01)) ? TCV_PIN_FREE :
                i[4] ? TCV_CENTER_PWM : i[3] ? TCV_EDGE_PWM :
                i[2] ? TCV_COMPARE : TCV_CAPTURE;
            chk({29'h0, mode}, {29'h0, e}, "mode decode");
        end
    endtask
    task automatic t_buf;
        wr(`TCV_OFF_GCTL, 32'h0);
        wr(`TCV_OFF_CSC, 32'h14);
        wr(`TCV_OFF_VHI, 32'h12);
        rd(`TCV_OFF_VHI, 32'h0, "half written");
        wr(`TCV_OFF_VLO, 32'h34);
        rd(`TCV_OFF_VHI, 32'h12, "high no clock");
        rd(`TCV_OFF_VLO, 32'h34, "low no clock");
        wr(`TCV_OFF_GCTL, 32'h2);
        wr(`TCV_OFF_VLO, 32'h78);
        wr(`TCV_OFF_VHI, 32'h56);
        rd(`TCV_OFF_VHI, 32'h12, "before step");
        @(posedge clk) step <= 1'b1;
        @(posedge clk) step <= 1'b0;
        rd(`TCV_OFF_VHI, 32'h56, "high after step");
        rd(`TCV_OFF_VLO, 32'h78, "low after step");
    endtask
    task automatic t_dbg;
        wr(`TCV_OFF_GCTL, 32'h0);
        wr(`TCV_OFF_VLO, 32'h9A);
        @(posedge clk) dbg <= 1'b1;
        wr(`TCV_OFF_VHI, 32'hAA);
        rd(`TCV_OFF_VHI, 32'hAA, "debug direct");
        rd(`TCV_OFF_VLO, 32'h78, "debug live low");
        @(posedge clk) dbg <= 1'b0;
        wr(`TCV_OFF_VHI, 32'h77);
        rd(`TCV_OFF_VHI, 32'h77, "sequence done");
        rd(`TCV_OFF_VLO, 32'h9A, "buffered low kept");
    endtask
    task automatic t_cmp;
        wr(`TCV_OFF_GCTL, 32'h2);
        @(posedge clk) begin
            cnt <= 16'h779A;
            step <= 1'b1;
        end
        @(posedge clk) step <= 1'b0;
        @(negedge clk);
        chk({30'h0, pin_o, oe}, 32'h3, "toggle on match");
        rd(`TCV_OFF_CSC, 32'h94, "compare flag");
        wr(`TCV_OFF_CSC, 32'h10);
        rd(`TCV_OFF_CSC, 32'h10, "software compare");
        @(posedge clk) step <= 1'b1;
        @(posedge clk) step <= 1'b0;
        @(negedge clk);
        chk({30'h0, pin_o, oe}, 32'h2, "pin left alone");
        rd(`TCV_OFF_CSC, 32'h90, "software match flag");
        wr(`TCV_OFF_GCTL, 32'h0);
    endtask
    task automatic t_cap;
        wr(`TCV_OFF_CSC, 32'h44);
        pin_edge(16'h1234);
        rd(`TCV_OFF_CSC, 32'hC4, "capture flag");
        chk({31'h0, irq}, 32'h1, "irq level");
        rd(`TCV_OFF_VHI, 32'h12, "captured high");
        pin_edge(16'h5678);
        rd(`TCV_OFF_VLO, 32'h34, "coherent low");
        wr(`TCV_OFF_VHI, 32'hFF);
        rd(`TCV_OFF_VHI, 32'h56, "write ignored");
        rd(`TCV_OFF_CSC, 32'hC4, "flag still set");
        wr(`TCV_OFF_CSC, 32'h44);
        rd(`TCV_OFF_CSC, 32'h44, "flag cleared");
        pin_edge(16'h9ABC);
        rd(`TCV_OFF_VLO, 32'hBC, "latch reset");
    endtask
    task automatic close_out;
        $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            n_fail++;
            close_out();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_mode();
        t_buf();
        t_dbg();
        t_cmp();
        t_cap();
        close_out();
    end
endmodule
`default_nettype wire
